/* File: ssdpr_defs.svh */
// constants of the small simple dual-port memory block
`ifndef SSDPR_DEFS_SVH
`define SSDPR_DEFS_SVH

// ---------------------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------------------
`define SSDPR_WORDS 32
`define SSDPR_WORD_W 18
`define SSDPR_WORD_AW 5
`define SSDPR_ADDR_W 9
`define SSDPR_DATA_W 16
`define SSDPR_TOTAL_BITS 576
`define SSDPR_PTR_W 9
`define SSDPR_CNT_W 10
`define SSDPR_BE_W 2

// ---------------------------------------------------------------------------
// depths of each width mode
// ---------------------------------------------------------------------------
`define SSDPR_DEPTH_1 10'h200
`define SSDPR_DEPTH_2 10'h100
`define SSDPR_DEPTH_4 10'h080
`define SSDPR_DEPTH_8 10'h040
`define SSDPR_DEPTH_16 10'h020

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define SSDPR_ZERO_WORD 18'h00000
`define SSDPR_ZERO_PTR 9'h000
`define SSDPR_ZERO_CNT 10'h000

`endif

/* File: ssdpr_pkg.sv */
// types of the small simple dual-port memory block
package ssdpr_pkg;

    // -----------------------------------------------------------------------
    // modes and widths
    // -----------------------------------------------------------------------
    typedef enum logic [2:0] {
        mode_sdp_ram,
        mode_sp_ram,
        mode_fifo,
        mode_rom,
        mode_shift
    } ssdpr_mode_type;

    typedef enum logic [2:0] {
        width_1,
        width_2,
        width_4,
        width_8,
        width_9,
        width_16,
        width_18
    } ssdpr_width_type;

    // -----------------------------------------------------------------------
    // port carriers
    // -----------------------------------------------------------------------
    typedef struct packed {
        ssdpr_mode_type mode;
        ssdpr_width_type wr_width;
        ssdpr_width_type rd_width;
        logic rd_on_out;
        logic out_on_out;
        logic out_bypass;
    } ssdpr_cfg_type;

    typedef struct packed {
        logic en;
        logic [8:0] addr;
        logic [17:0] data;
        logic [1:0] byte_en;
    } ssdpr_wr_type;

    typedef struct packed {
        logic en;
        logic [8:0] addr;
    } ssdpr_rd_type;

    typedef struct packed {
        logic wr_go;
        logic [8:0] wr_addr;
        logic [17:0] wr_data;
        logic [1:0] wr_be;
        logic [8:0] rd_addr;
        ssdpr_width_type rd_width;
        logic [8:0] wptr;
        logic [8:0] rptr;
        logic [9:0] count;
        logic fifo_full;
        logic fifo_empty;
        logic [17:0] out_q;
    } ssdpr_state_type;

endpackage

/* File: ssdpr_mem.sv */
// storage array of 32 words by 18 bits with bit-masked write and registered read
`timescale 1ns/1ps
`default_nettype none
`include "ssdpr_defs.svh"

module ssdpr_mem #(
    parameter logic [575:0] INIT_IMAGE = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write side
    input wire logic wr_en,
    input wire logic [4:0] wr_word,
    input wire logic [17:0] wr_mask,
    input wire logic [17:0] wr_data,
    // read side
    input wire logic rd_en,
    input wire logic [4:0] rd_word,
    output logic [17:0] rd_q
);

    // -----------------------------------------------------------------------
    // array
    // -----------------------------------------------------------------------
    // 576 cells
    logic [`SSDPR_WORD_W-1:0] mem [0:`SSDPR_WORDS-1];

    initial begin
        for (int i = 0; i < `SSDPR_WORDS; i++) begin
            mem[i] = INIT_IMAGE[i*`SSDPR_WORD_W +: `SSDPR_WORD_W];
        end
    end

    // masked lane write
    // plain always: the preload above writes the array too
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_word] <= (mem[wr_word] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= `SSDPR_ZERO_WORD;
        end else if (rd_en) begin
            rd_q <= mem[rd_word];
        end
    end

    // -----------------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------------
    a_lane_mask_kept: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en |=> ((mem[$past(wr_word)] & ~$past(wr_mask))
                   == ($past(mem[wr_word]) & ~$past(wr_mask))))
        else $error("unselected lanes changed by a write");

    a_collide_old_data: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_en && wr_en && rd_word == wr_word) |=> rd_q == $past(mem[rd_word]))
        else $error("colliding read did not return old data");

endmodule
`default_nettype wire

/* File: ssdpr_top.sv */
// small simple dual-port memory block: width modes, fifo, shift and output register
`timescale 1ns/1ps
`default_nettype none
`include "ssdpr_defs.svh"

module ssdpr_top #(
    parameter logic [575:0] INIT_IMAGE = '0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // configuration
    input wire ssdpr_pkg::ssdpr_cfg_type cfg,
    // the two block clocks as enable pulses, their enables and the clear
    input wire logic in_tick,
    input wire logic out_tick,
    input wire logic in_clk_en,
    input wire logic out_clk_en,
    input wire logic out_clr,
    // write and read requests
    input wire ssdpr_pkg::ssdpr_wr_type wr,
    input wire ssdpr_pkg::ssdpr_rd_type rd,
    // results
    output logic [17:0] rd_data,
    output logic fifo_full,
    output logic fifo_empty
);
    import ssdpr_pkg::*;

    // -----------------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------------
    function automatic logic [4:0] word_of(ssdpr_width_type w, logic [8:0] a);
        case (w)
            width_1: word_of = a[8:4];
            width_2: word_of = a[7:3];
            width_4: word_of = a[6:2];
            width_8, width_9: word_of = a[5:1];
            default: word_of = a[4:0];
        endcase
    endfunction

    function automatic logic [9:0] depth_of(ssdpr_width_type w);
        case (w)
            width_1: depth_of = `SSDPR_DEPTH_1;
            width_2: depth_of = `SSDPR_DEPTH_2;
            width_4: depth_of = `SSDPR_DEPTH_4;
            width_8, width_9: depth_of = `SSDPR_DEPTH_8;
            default: depth_of = `SSDPR_DEPTH_16;
        endcase
    endfunction

    // data bits sit in 7:0 and 16:9, parity in 8 and 17
    function automatic logic [17:0] spread(logic [15:0] d);
        spread = {1'b0, d[15:8], 1'b0, d[7:0]};
    endfunction

    function automatic logic [17:0] lane_mask(ssdpr_width_type w, logic [8:0] a,
                                              logic [1:0] be);
        case (w)
            width_1: lane_mask = spread(16'h0001 << a[3:0]);
            width_2: lane_mask = spread(16'h0003 << {a[2:0], 1'b0});
            width_4: lane_mask = spread(16'h000f << {a[1:0], 2'b00});
            width_8: lane_mask = spread(16'h00ff << {a[0], 3'b000});
            width_9: lane_mask = a[0] ? 18'h3fe00 : 18'h001ff;
            width_16: lane_mask = spread({{8{be[1]}}, {8{be[0]}}});
            default: lane_mask = {{9{be[1]}}, {9{be[0]}}};
        endcase
    endfunction

    function automatic logic [17:0] lane_data(ssdpr_width_type w, logic [17:0] d);
        case (w)
            width_1: lane_data = spread({16{d[0]}});
            width_2: lane_data = spread({8{d[1:0]}});
            width_4: lane_data = spread({4{d[3:0]}});
            width_8: lane_data = spread({2{d[7:0]}});
            width_9: lane_data = {2{d[8:0]}};
            width_16: lane_data = spread(d[15:0]);
            default: lane_data = d;
        endcase
    endfunction

    function automatic logic [17:0] extract(ssdpr_width_type w, logic [8:0] a,
                                            logic [17:0] q);
        logic [15:0] d;
        d = {q[16:9], q[7:0]};
        case (w)
            width_1: extract = {17'h00000, d[a[3:0]]};
            width_2: extract = {16'h0000, d[{a[2:0], 1'b0} +: 2]};
            width_4: extract = {14'h0000, d[{a[1:0], 2'b00} +: 4]};
            width_8: extract = {10'h000, d[{a[0], 3'b000} +: 8]};
            width_9: extract = {9'h000, (a[0] ? q[17:9] : q[8:0])};
            width_16: extract = {2'b00, d};
            default: extract = q;
        endcase
    endfunction

    function automatic logic [8:0] step(logic [8:0] p, logic [9:0] depth);
        step = ((10'(p) + 10'h001) == depth) ? `SSDPR_ZERO_PTR : p + 9'h001;
    endfunction

    // -----------------------------------------------------------------------
    // reset release
    // -----------------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // -----------------------------------------------------------------------
    // clock selection
    // -----------------------------------------------------------------------
    ssdpr_state_type st;
    ssdpr_state_type next_st;
    logic in_go;
    logic out_go;
    logic wr_tick;
    logic rd_tick;
    logic out_load;
    logic push;
    logic pop;
    logic rd_fire;
    logic [8:0] rd_addr_sel;
    ssdpr_width_type rd_width_sel;
    logic [9:0] depth;
    logic [17:0] mem_q;
    logic [17:0] rd_view;
    logic [4:0] wr_word_now;
    logic [17:0] wr_mask_now;
    logic [17:0] wr_lane_now;

    assign in_go = in_tick & in_clk_en;
    assign out_go = out_tick & out_clk_en;
    // write side on the input clock
    assign wr_tick = in_go;
    assign rd_tick = cfg.rd_on_out ? out_go : in_go;
    assign out_load = cfg.out_on_out ? out_go : in_go;
    assign depth = depth_of(cfg.wr_width);

    // -----------------------------------------------------------------------
    // request steering
    // -----------------------------------------------------------------------
    always_comb begin
        push = 1'b0;
        pop = 1'b0;
        rd_fire = rd_tick & rd.en;
        rd_addr_sel = rd.addr;
        rd_width_sel = cfg.rd_width;
        case (cfg.mode)
            mode_sp_ram: begin
                rd_addr_sel = wr.addr;
                rd_width_sel = cfg.wr_width;
            end
            mode_fifo: begin
                push = wr_tick & wr.en & ~st.fifo_full;
                pop = rd_tick & rd.en & ~st.fifo_empty;
                rd_fire = pop;
                rd_addr_sel = st.rptr;
                rd_width_sel = cfg.wr_width;
            end
            mode_shift: begin
                push = wr_tick & wr.en;
                rd_fire = push;
                rd_addr_sel = st.wptr;
                rd_width_sel = cfg.wr_width;
            end
            default: begin
                rd_width_sel = cfg.rd_width;
            end
        endcase
    end

    // -----------------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (wr_tick) begin
            next_st.wr_addr = (cfg.mode == mode_fifo || cfg.mode == mode_shift)
                              ? st.wptr : wr.addr;
            next_st.wr_data = wr.data;
            next_st.wr_be = wr.byte_en;
        end
        next_st.wr_go = wr_tick & wr.en & (cfg.mode != mode_rom)
                        & ((cfg.mode != mode_fifo) | ~st.fifo_full);
        if (rd_fire) begin
            next_st.rd_addr = rd_addr_sel;
            next_st.rd_width = rd_width_sel;
        end
        if (push) begin
            next_st.wptr = step(st.wptr, depth);
        end
        if (pop) begin
            next_st.rptr = step(st.rptr, depth);
        end
        if (cfg.mode == mode_fifo) begin
            next_st.count = st.count + 10'(push) - 10'(pop);
            next_st.fifo_full = (next_st.count == depth);
            next_st.fifo_empty = (next_st.count == `SSDPR_ZERO_CNT);
        end
        if (out_clr) begin
            next_st.out_q = `SSDPR_ZERO_WORD;
        end else if (out_load) begin
            next_st.out_q = rd_view;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{wr_go: 1'b0, wr_addr: `SSDPR_ZERO_PTR, wr_data: `SSDPR_ZERO_WORD,
                    wr_be: 2'b00, rd_addr: `SSDPR_ZERO_PTR, rd_width: width_1,
                    wptr: `SSDPR_ZERO_PTR, rptr: `SSDPR_ZERO_PTR,
                    count: `SSDPR_ZERO_CNT, fifo_full: 1'b0, fifo_empty: 1'b1,
                    out_q: `SSDPR_ZERO_WORD};
        end else begin
            st <= next_st;
        end
    end

    // -----------------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------------
    // width decode of both ports; parity lanes
    assign wr_word_now = word_of(cfg.wr_width, st.wr_addr);
    assign wr_mask_now = lane_mask(cfg.wr_width, st.wr_addr, st.wr_be);
    assign wr_lane_now = lane_data(cfg.wr_width, st.wr_data);

    ssdpr_mem #(
        .INIT_IMAGE(INIT_IMAGE)
    ) u_mem (
        .clk(core_clk),
        .rst_n(rst_n),
        .wr_en(st.wr_go),
        .wr_word(wr_word_now),
        .wr_mask(wr_mask_now),
        .wr_data(wr_lane_now),
        .rd_en(rd_fire),
        .rd_word(word_of(rd_width_sel, rd_addr_sel)),
        .rd_q(mem_q)
    );

    assign rd_view = extract(st.rd_width, st.rd_addr, mem_q);

    assign rd_data = cfg.out_bypass ? rd_view : st.out_q;
    assign fifo_full = st.fifo_full;
    assign fifo_empty = st.fifo_empty;

    // -----------------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_rom_no_write: assert property (
        cfg.mode == mode_rom |=> !st.wr_go)
        else $error("write issued in rom mode");

    a_wr_on_inclk: assert property (
        st.wr_go |-> $past(in_tick) && $past(in_clk_en))
        else $error("write not taken on the input clock");

    a_rd_on_outclk: assert property (
        (cfg.rd_on_out && !out_tick && cfg.mode != mode_shift) |-> !rd_fire)
        else $error("read fired without the output clock");

    a_out_clear: assert property (
        out_clr |=> st.out_q == `SSDPR_ZERO_WORD)
        else $error("output register not cleared");

    a_out_freeze: assert property (
        (!out_load && !out_clr) |=> $stable(st.out_q))
        else $error("output register moved while frozen");

    a_out_capture: assert property (
        (out_load && !out_clr) |=> st.out_q == $past(rd_view))
        else $error("output register missed read data");

    a_fifo_full_flag: assert property (
        cfg.mode == mode_fifo |-> st.fifo_full == (st.count == depth))
        else $error("fifo full flag wrong");

    a_fifo_no_overrun: assert property (
        (cfg.mode == mode_fifo && st.fifo_full && !pop) |=> $stable(st.count))
        else $error("fifo count moved while full");

    a_width_lane_w9: assert property (
        (st.wr_go && cfg.wr_width == width_9)
        |=> (u_mem.mem[$past(wr_word_now)] & $past(wr_mask_now))
            == ($past(wr_lane_now) & $past(wr_mask_now)))
        else $error("parity width write did not land");

    c_fifo_fills: cover property (cfg.mode == mode_fifo && st.fifo_full);
    c_shift_run: cover property (cfg.mode == mode_shift && push ##1 push);
    c_mixed_read: cover property (rd_fire && cfg.rd_width != cfg.wr_width);
    c_bypass_read: cover property (cfg.out_bypass && rd_fire);

endmodule
`default_nettype wire

/* File: ssdpr_fabric.sv */
// model of the surrounding logic array that makes the two block clock ticks
`timescale 1ns/1ps
`default_nettype none

module ssdpr_fabric (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // pace select: 0 ticks every cycle, 1 alternating ticks
    input wire logic slow,
    // ticks towards the block
    output logic in_tick,
    output logic out_tick
);
    logic phase;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end

    assign in_tick = slow ? phase : 1'b1;
    assign out_tick = slow ? ~phase : 1'b1;
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench of the small simple dual-port memory block
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error %0t: mismatch got %h exp %h", $time, got, exp); end end

module testbench;
    import ssdpr_pkg::*;
    localparam logic [575:0] INIT = (576'h15a5a << 126) | (576'h2c0de << 54);

    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic slow = 1'b0;
    ssdpr_cfg_type cfg;
    logic in_tick, out_tick, in_clk_en, out_clk_en, out_clr;
    ssdpr_wr_type wr;
    ssdpr_rd_type rd;
    logic [17:0] rd_data;
    logic fifo_full, fifo_empty;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #50 core_clk = ~core_clk;

    ssdpr_fabric fab (.core_clk(core_clk), .resetn(resetn), .slow(slow),
        .in_tick(in_tick), .out_tick(out_tick));

    ssdpr_top #(.INIT_IMAGE(INIT)) dut (.core_clk(core_clk), .resetn(resetn), .cfg(cfg),
        .in_tick(in_tick), .out_tick(out_tick), .in_clk_en(in_clk_en),
        .out_clk_en(out_clk_en), .out_clr(out_clr), .wr(wr), .rd(rd),
        .rd_data(rd_data), .fifo_full(fifo_full), .fifo_empty(fifo_empty));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic set_cfg(ssdpr_mode_type m, ssdpr_width_type ww, ssdpr_width_type rw,
                           logic ro, logic oo, logic byp);
        @(posedge core_clk);
        cfg <= '{m, ww, rw, ro, oo, byp};
        repeat (2) @(posedge core_clk);
    endtask

    task automatic do_wr(logic [8:0] a, logic [17:0] d, logic [1:0] be, int hold);
        @(posedge core_clk);
        wr <= '{1'b1, a, d, be};
        repeat (hold) @(posedge core_clk);
        wr.en <= 1'b0;
    endtask

    task automatic do_rd(logic [8:0] a, int hold);
        @(posedge core_clk);
        rd <= '{1'b1, a};
        repeat (hold) @(posedge core_clk);
        rd.en <= 1'b0;
        #1;
    endtask

    function automatic logic [17:0] pick(logic [17:0] w, int wd, int s);
        logic [15:0] d;
        d = {w[16:9], w[7:0]};
        case (wd)
            1: pick = {17'h00000, d[s]};
            2: pick = {16'h0000, d[2*s+:2]};
            4: pick = {14'h0000, d[4*s+:4]};
            8: pick = {10'h000, d[8*s+:8]};
            9: pick = s ? {9'h000, w[17:9]} : {9'h000, w[8:0]};
            16: pick = {2'h0, d};
            default: pick = w;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK(rd_data, 18'h00000)
        `CHK(fifo_empty, 1'b1)
        `CHK(fifo_full, 1'b0)
    endtask

    task automatic t_preload_collide();
        set_cfg(mode_sdp_ram, width_18, width_18, 1'b0, 1'b0, 1'b1);
        do_rd(9'h003, 1);
        `CHK(rd_data, 18'h2c0de)
        @(posedge core_clk);
        wr <= '{1'b1, 9'h007, 18'h00abc, 2'b11};
        rd <= '{1'b1, 9'h007};
        @(posedge core_clk);
        wr.en <= 1'b0;
        rd.en <= 1'b0;
        #1;
        `CHK(rd_data, 18'h15a5a)
        do_rd(9'h007, 1);
        `CHK(rd_data, 18'h00abc)
    endtask

    task automatic t_byte_en();
        do_wr(9'h006, 18'h3ffff, 2'b11, 1);
        do_wr(9'h006, 18'h00000, 2'b10, 1);
        do_rd(9'h006, 1);
        `CHK(rd_data, 18'h001ff)
    endtask

    task automatic t_mixed();
        ssdpr_width_type wt[7] = '{width_1, width_2, width_4, width_8, width_9,
                                   width_16, width_18};
        int wd[7] = '{1, 2, 4, 8, 9, 16, 18};
        int fac[7] = '{16, 8, 4, 2, 2, 1, 1};
        int sh[7] = '{9, 3, 2, 1, 1, 0, 0};
        do_wr(9'h005, 18'h2a5c3, 2'b11, 1);
        for (int i = 0; i < 7; i++) begin
            set_cfg(mode_sdp_ram, width_18, wt[i], 1'b0, 1'b0, 1'b1);
            do_rd(9'(5 * fac[i] + sh[i]), 1);
            `CHK(rd_data, pick(18'h2a5c3, wd[i], sh[i]))
        end
    endtask

    task automatic t_parity_sp();
        set_cfg(mode_sdp_ram, width_9, width_18, 1'b0, 1'b0, 1'b1);
        do_wr(9'h015, 18'h001a5, 2'b00, 1);
        do_rd(9'h00a, 1);
        `CHK(rd_data, 18'h34a00)
        set_cfg(mode_sp_ram, width_18, width_18, 1'b0, 1'b0, 1'b1);
        do_wr(9'h00c, 18'h1e1e1, 2'b11, 1);
        do_rd(9'h003, 1);
        `CHK(rd_data, 18'h1e1e1)
    endtask

    task automatic t_shift();
        set_cfg(mode_shift, width_18, width_18, 1'b0, 1'b0, 1'b1);
        @(posedge core_clk);
        for (int i = 0; i < 34; i++) begin
            wr <= '{1'b1, 9'h000, 18'(i * 5 + 2), 2'b11};
            @(posedge core_clk);
            #1;
            if (i >= 32) `CHK(rd_data, 18'((i - 32) * 5 + 2))
        end
        wr.en <= 1'b0;
    endtask

    task automatic t_out_reg();
        set_cfg(mode_sdp_ram, width_18, width_18, 1'b0, 1'b1, 1'b0);
        @(posedge core_clk);
        out_clr <= 1'b1;
        out_clk_en <= 1'b0;
        @(posedge core_clk);
        out_clr <= 1'b0;
        #1;
        `CHK(rd_data, 18'h00000)
        do_rd(9'h003, 1);
        @(posedge core_clk);
        #1;
        `CHK(rd_data, 18'h00000)
        out_clk_en <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK(rd_data, 18'h2c0de)
        out_clr <= 1'b1;
        @(posedge core_clk);
        out_clr <= 1'b0;
        do_rd(9'h003, 1);
        @(posedge core_clk);
        #1;
        `CHK(rd_data, 18'h2c0de)
    endtask

    task automatic t_gates_rom();
        set_cfg(mode_sdp_ram, width_18, width_18, 1'b1, 1'b0, 1'b1);
        in_clk_en <= 1'b0;
        do_wr(9'h003, 18'h11111, 2'b11, 1);
        do_rd(9'h003, 1);
        `CHK(rd_data, 18'h2c0de)
        in_clk_en <= 1'b1;
        set_cfg(mode_rom, width_18, width_18, 1'b0, 1'b0, 1'b1);
        do_wr(9'h003, 18'h22222, 2'b11, 1);
        do_rd(9'h003, 1);
        `CHK(rd_data, 18'h2c0de)
        set_cfg(mode_sdp_ram, width_18, width_18, 1'b0, 1'b0, 1'b1);
        slow <= 1'b1;
        do_wr(9'h009, 18'h3c3c3, 2'b11, 2);
        do_rd(9'h009, 2);
        `CHK(rd_data, 18'h3c3c3)
        slow <= 1'b0;
    endtask

    task automatic t_fifo();
        set_cfg(mode_fifo, width_18, width_18, 1'b0, 1'b0, 1'b1);
        @(posedge core_clk);
        for (int i = 0; i < 33; i++) begin
            wr <= '{1'b1, 9'h000, 18'(i * 3 + 1), 2'b11};
            @(posedge core_clk);
        end
        wr.en <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK(fifo_full, 1'b1)
        for (int i = 0; i < 33; i++) begin
            rd <= '{1'b1, 9'h000};
            @(posedge core_clk);
            #1;
            if (i < 32) `CHK(rd_data, 18'(i * 3 + 1))
        end
        rd.en <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK(fifo_empty, 1'b1)
        `CHK(fifo_full, 1'b0)
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        cfg = '{mode_sdp_ram, width_18, width_18, 1'b0, 1'b0, 1'b1};
        in_clk_en = 1'b1;
        out_clk_en = 1'b1;
        out_clr = 1'b0;
        wr = '0;
        rd = '0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        t_reset();
        repeat (3) @(posedge core_clk);
        t_preload_collide();
        t_byte_en();
        t_mixed();
        t_parity_sp();
        t_out_reg();
        t_gates_rom();
        t_fifo();
        t_shift();
        final_report();
    end
endmodule
`default_nettype wire
